// *** common/shadow_reg_pkg.sv ***
package shadow_reg_pkg;

	// --------------------------------------------------------------
	// command codes
	// --------------------------------------------------------------
	localparam logic [7:0] ARM_WRITE_CMD         = 8'h06;
	localparam logic [7:0] DISARM_WRITE_CMD      = 8'h04;
	localparam logic [7:0] LEGACY_REG_WRITE_CMD  = 8'h01;
	localparam logic [7:0] STATUS_ONE_READ_CMD   = 8'h05;
	localparam logic [7:0] GENERIC_REG_READ_CMD  = 8'h65;
	localparam logic [7:0] GENERIC_REG_WRITE_CMD = 8'h71;

	// --------------------------------------------------------------
	// register address space
	// --------------------------------------------------------------
	localparam int          ADDR_W       = 24;
	localparam int          VOLATILE_BIT = 23;
	localparam int          NV_BYTES     = 20;
	localparam int          V_BYTES      = 7;
	localparam int          IDX_W        = 5;
	// persistent byte indices
	localparam logic [4:0]  NV_STATUS_ONE = 5'h00;
	localparam logic [4:0]  NV_CONFIG_ONE = 5'h01;
	localparam logic [4:0]  NV_CONFIG_TWO = 5'h02;
	localparam logic [4:0]  NV_CONFIG_THR = 5'h03;
	localparam logic [4:0]  NV_LEARNING   = 5'h04;
	localparam logic [4:0]  NV_REGION_LO  = 5'h05;
	localparam logic [4:0]  NV_PASSWORD   = 5'h07;
	localparam logic [4:0]  NV_POINTER    = 5'h0F;
	// working byte indices
	localparam logic [4:0]  V_STATUS_ONE  = 5'h00;
	localparam logic [4:0]  V_STATUS_TWO  = 5'h01;
	localparam logic [4:0]  V_CONFIG_ONE  = 5'h02;
	localparam logic [4:0]  V_LEARNING    = 5'h05;
	localparam logic [4:0]  V_BLOCK_LOCK  = 5'h06;
	// one-time-programmable persistent bytes: learning, region guard, password
	localparam logic [19:0] NV_OTP_MASK   = 20'h07FF0;

	// --------------------------------------------------------------
	// status register one fields
	// --------------------------------------------------------------
	localparam int          LOCK_POS    = 7;
	localparam int          ARM_POS     = 1;
	localparam int          BUSY_POS    = 0;
	localparam logic [7:0]  SR1_RO_MASK = 8'h03;

	// --------------------------------------------------------------
	// factory and reset values
	// --------------------------------------------------------------
	localparam logic [159:0] NV_FACTORY      = 160'h0;
	localparam logic [7:0]   STATUS_TWO_INIT = 8'h00;
	localparam logic [7:0]   BLOCK_LOCK_INIT = 8'h00;

	// --------------------------------------------------------------
	// cell update timing in cycles
	// --------------------------------------------------------------
	localparam int ERASE_CYCLES_DEF   = 64;
	localparam int PROGRAM_CYCLES_DEF = 32;
	localparam int CYCLE_W            = 16;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_ERASE, SEQ_PROGRAM} seq_state_t;

endpackage

// *** hdl/nv_cell_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module nv_cell_timer
	import shadow_reg_pkg::*;
#(
	parameter int ERASE_CYCLES   = ERASE_CYCLES_DEF,
	parameter int PROGRAM_CYCLES = PROGRAM_CYCLES_DEF
)(
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic start,
	input  wire logic with_erase,
	input  wire logic abort,
	output var  logic done
);
	seq_state_t         state;
	logic [CYCLE_W-1:0] count;

	// --------------------------------------------------------------
	// erase phase then program phase
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= SEQ_IDLE;
			count <= '0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				state <= SEQ_IDLE;
			end else begin
				unique case (state)
					SEQ_IDLE: begin
						if (start) begin
							state <= with_erase ? SEQ_ERASE : SEQ_PROGRAM;
							count <= with_erase ? CYCLE_W'(ERASE_CYCLES - 1) : CYCLE_W'(PROGRAM_CYCLES - 1);
						end
					end
					SEQ_ERASE: begin
						if (count == '0) begin
							state <= SEQ_PROGRAM;
							count <= CYCLE_W'(PROGRAM_CYCLES - 1);
						end else begin
							count <= count - 1'b1;
						end
					end
					SEQ_PROGRAM: begin
						if (count == '0) begin
							state <= SEQ_IDLE;
							done  <= 1'b1;
						end else begin
							count <= count - 1'b1;
						end
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** hdl/shadow_register_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
// Function
// - registers are reached only through the fixed register command codes.
// - shadowed registers keep a persistent copy and a working copy.
// - 05h and working-address reads of a shadowed register return its working copy.
// - reload_req reloads working copies from their persistent copies; resetn restores factory values in both.
// - rewritable persistent write erases, programs, then refreshes the working copy.
// - one-time programming also refreshes the matching working bits.
// - working-only writes leave the persistent copy untouched.
// - working defaults apply after reset; persistent defaults are factory values.
// - provide region guard, password, block lock access and pointer guard registers.
// - learning pattern has OTP and working copies; status/config bytes are 8 bits.
// - persistent bit 7 seeds the register lock bit, ships 0.
// - persistent bit 6 seeds the granularity select bit, ships 0.
// - persistent bit 5 seeds the protect origin bit, ships 0.
// - persistent bits 4 to 2 seed the range bits, ship 000.
// - persistent bit 1 seeds the write arm latch, fixed 0, read-only.
// - persistent bit 0 seeds the busy flag, fixed 0, read-only.
// - 06h arms and 04h disarms register writes.
// - 01h and 71h write status one persistent; 65h reads it.
// - 05h returns the working status register one.
// - write arm latch must be set before any register write starts.
// - register lock bit follows its persistent default on every change; a working write to status one (800000h) sets it directly.
module shadow_register_bank
	import shadow_reg_pkg::*;
#(
	parameter int ERASE_CYCLES   = ERASE_CYCLES_DEF,
	parameter int PROGRAM_CYCLES = PROGRAM_CYCLES_DEF
)(
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              reload_req,
	input  wire logic              wp_n,
	input  wire logic              cmd_valid,
	input  wire logic [7:0]        cmd_code,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [7:0]        cmd_data,
	output var  logic              rsp_valid,
	output var  logic [7:0]        rsp_data,
	output var  logic [7:0]        status_one_working
);

	// --------------------------------------------------------------
	// storage
	// --------------------------------------------------------------
	// two copies kept
	logic [NV_BYTES*8-1:0] nv_image;
	logic [V_BYTES*8-1:0]  v_image;
	logic [IDX_W-1:0]      pend_idx;
	logic [7:0]            pend_data;
	logic                  seq_done;

	// working copy image derived from a persistent image
	function automatic logic [V_BYTES*8-1:0] reload_image(input logic [NV_BYTES*8-1:0] nv);
		logic [V_BYTES*8-1:0] v;
		v = '0;
		v[8*V_STATUS_ONE +: 8] = nv[8*NV_STATUS_ONE +: 8];
		v[8*V_STATUS_TWO +: 8] = STATUS_TWO_INIT;
		v[8*V_CONFIG_ONE +: 24] = nv[8*NV_CONFIG_ONE +: 24];
		v[8*V_LEARNING +: 8]    = nv[8*NV_LEARNING +: 8];
		v[8*V_BLOCK_LOCK +: 8]  = BLOCK_LOCK_INIT;
		return v;
	endfunction

	// working index shadowing a persistent byte, valid flag in bit 5
	function automatic logic [5:0] shadow_of(input logic [IDX_W-1:0] idx);
		logic [5:0] r;
		r = '0;
		unique case (idx)
			NV_STATUS_ONE: r = {1'b1, V_STATUS_ONE};
			NV_CONFIG_ONE,
			NV_CONFIG_TWO,
			NV_CONFIG_THR: r = {1'b1, idx + 5'd1};
			NV_LEARNING:   r = {1'b1, V_LEARNING};
			default:       r = '0;
		endcase
		return r;
	endfunction

	// --------------------------------------------------------------
	// command decode
	// --------------------------------------------------------------
	logic             armed;
	logic             busy;
	logic             reg_locked;
	logic [IDX_W-1:0] idx;
	logic             addr_hi_clear;
	logic             nv_hit;
	logic             v_hit;
	logic             nv_guarded;
	logic             v_guarded;
	logic             is_legacy_wr;
	logic             is_generic_wr;
	logic             write_ok;
	logic             start_nv;
	logic             vol_write;
	logic [IDX_W-1:0] nv_idx;
	logic [7:0]       nv_old;
	logic [7:0]       nv_new;
	logic             nv_is_otp;
	logic [5:0]       pend_shadow;

	assign armed         = v_image[LOCK_POS - LOCK_POS + ARM_POS];
	assign busy          = v_image[BUSY_POS];
	assign reg_locked    = v_image[LOCK_POS] & ~wp_n;
	assign idx           = cmd_addr[IDX_W-1:0];
	assign addr_hi_clear = cmd_addr[VOLATILE_BIT-1:IDX_W] == '0;
	assign nv_hit        = ~cmd_addr[VOLATILE_BIT] & addr_hi_clear & (idx < IDX_W'(NV_BYTES));
	assign v_hit         = cmd_addr[VOLATILE_BIT] & addr_hi_clear & (idx < IDX_W'(V_BYTES));
	assign nv_guarded    = idx <= NV_LEARNING;
	assign v_guarded     = (idx != V_STATUS_TWO) && (idx != V_BLOCK_LOCK);
	assign is_legacy_wr  = cmd_code == LEGACY_REG_WRITE_CMD;
	assign is_generic_wr = cmd_code == GENERIC_REG_WRITE_CMD;

	assign write_ok  = cmd_valid & ~busy & armed;
	assign start_nv  = write_ok & ((is_legacy_wr & ~reg_locked)
	                 | (is_generic_wr & nv_hit & ~(nv_guarded & reg_locked)));
	assign vol_write = write_ok & is_generic_wr & v_hit & ~(v_guarded & reg_locked);
	assign nv_idx    = is_legacy_wr ? NV_STATUS_ONE : idx;
	assign nv_old    = nv_image[8*nv_idx +: 8];
	assign nv_is_otp = NV_OTP_MASK[nv_idx];

	always_comb begin
		if (nv_is_otp)
			nv_new = nv_old | cmd_data;
		else if (nv_idx == NV_STATUS_ONE)
			nv_new = (cmd_data & ~SR1_RO_MASK) | (nv_old & SR1_RO_MASK);
		else
			nv_new = cmd_data;
	end

	assign pend_shadow = shadow_of(pend_idx);

	// --------------------------------------------------------------
	// cell erase and program timing
	// --------------------------------------------------------------
	// erase only for rewritable bytes
	nv_cell_timer #(
		.ERASE_CYCLES   (ERASE_CYCLES),
		.PROGRAM_CYCLES (PROGRAM_CYCLES)
	) u_timer (
		.sys_clk    (sys_clk),
		.resetn     (resetn),
		.start      (start_nv),
		.with_erase (~nv_is_otp),
		.abort      (reload_req),
		.done       (seq_done)
	);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pend_idx  <= '0;
			pend_data <= '0;
		end else if (start_nv) begin
			pend_idx  <= nv_idx;
			pend_data <= nv_new;
		end
	end

	// --------------------------------------------------------------
	// persistent copy
	// --------------------------------------------------------------
	// factory contents
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			nv_image <= NV_FACTORY;
		end else if (seq_done && !reload_req) begin
			// commit programmed byte, a reload in the same cycle aborts it
			nv_image[8*pend_idx +: 8] <= pend_data;
		end
	end

	// --------------------------------------------------------------
	// working copy
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			v_image <= reload_image(NV_FACTORY);
		end else if (reload_req) begin
			v_image <= reload_image(nv_image);
		end else begin
			if (seq_done) begin
				if (pend_shadow[5])
					v_image[8*pend_shadow[4:0] +: 8] <= pend_data;
				if (pend_shadow[5] && pend_shadow[4:0] == V_STATUS_ONE)
					v_image[ARM_POS:BUSY_POS] <= 2'b00;
				v_image[BUSY_POS] <= 1'b0;
				v_image[ARM_POS]  <= 1'b0;
			end else if (start_nv) begin
				v_image[BUSY_POS] <= 1'b1;
			end else if (vol_write) begin
				if (idx == V_STATUS_ONE)
					v_image[7:2] <= cmd_data[7:2];
				else
					v_image[8*idx +: 8] <= cmd_data;
				v_image[ARM_POS] <= 1'b0;
			end else if (cmd_valid && !busy && cmd_code == ARM_WRITE_CMD) begin
				v_image[ARM_POS] <= 1'b1;
			end else if (cmd_valid && !busy && cmd_code == DISARM_WRITE_CMD) begin
				v_image[ARM_POS] <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// read answers
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
		end else begin
			rsp_valid <= cmd_valid & ((cmd_code == STATUS_ONE_READ_CMD) | (cmd_code == GENERIC_REG_READ_CMD));
			if (cmd_valid && cmd_code == STATUS_ONE_READ_CMD) begin
				rsp_data <= v_image[8*V_STATUS_ONE +: 8];
			end else if (cmd_valid && cmd_code == GENERIC_REG_READ_CMD) begin
				if (nv_hit)
					rsp_data <= nv_image[8*idx +: 8];
				else if (v_hit)
					rsp_data <= v_image[8*idx +: 8];
				else
					rsp_data <= 8'h00;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			status_one_working <= NV_FACTORY[7:0];
		else
			status_one_working <= v_image[7:0];
	end

endmodule
`default_nettype wire

// *** test/shadow_register_bank_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module shadow_register_bank_sva
	import shadow_reg_pkg::*;
#(
	parameter int ERASE_CYCLES   = ERASE_CYCLES_DEF,
	parameter int PROGRAM_CYCLES = PROGRAM_CYCLES_DEF
)(
	input wire logic              sys_clk,
	input wire logic              resetn,
	input wire logic              reload_req,
	input wire logic              wp_n,
	input wire logic              cmd_valid,
	input wire logic [7:0]        cmd_code,
	input wire logic [ADDR_W-1:0] cmd_addr,
	input wire logic [7:0]        cmd_data,
	input wire logic              rsp_valid,
	input wire logic [7:0]        rsp_data,
	input wire logic [7:0]        status_one_working
);
	localparam int BUSY_MAX = ERASE_CYCLES + PROGRAM_CYCLES + 2;
	logic busy;
	logic arm;
	logic is_read;
	logic arm_q;
	assign busy    = status_one_working[BUSY_POS];
	assign arm     = status_one_working[ARM_POS];
	assign is_read = cmd_valid && (cmd_code == STATUS_ONE_READ_CMD || cmd_code == GENERIC_REG_READ_CMD);
	// arm command one cycle back, not yet visible on the output
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			arm_q <= 1'b0;
		end else begin
			arm_q <= cmd_valid && cmd_code == ARM_WRITE_CMD;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	AST_READ_ANSWER: assert property (is_read |=> rsp_valid)
		else $error("read not answered");
	AST_RSP_ONLY_READ: assert property (rsp_valid |-> $past(is_read))
		else $error("answer without read");
	AST_SR1_VALUE: assert property (cmd_valid && cmd_code == STATUS_ONE_READ_CMD |=> rsp_data == status_one_working)
		else $error("status read not working copy");
	AST_RSP_HOLD: assert property (!rsp_valid |-> $stable(rsp_data))
		else $error("read data moved");
	AST_ARM_CAUSE: assert property ($rose(arm) |-> $past(cmd_valid, 2) && $past(cmd_code, 2) == ARM_WRITE_CMD)
		else $error("arm latch set without arm command");
	AST_BUSY_BOUND: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
		else $error("busy too long");
	AST_ARM_CLEARED: assert property ($fell(busy) |-> !arm)
		else $error("arm latch kept after write");
	AST_NEED_ARM: assert property (cmd_valid && cmd_code == LEGACY_REG_WRITE_CMD && !arm && !arm_q |=> ##1 !$rose(busy))
		else $error("write started unarmed");
	COV_READ: cover property (is_read ##1 rsp_valid);
	COV_BUSY: cover property ($rose(busy));
	COV_RELOAD: cover property (reload_req);
endmodule
`default_nettype wire

// *** test/host_cmd_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module host_cmd_model
	import shadow_reg_pkg::*;
(
	input  wire logic              sys_clk,
	output var  logic              cmd_valid,
	output var  logic [7:0]        cmd_code,
	output var  logic [ADDR_W-1:0] cmd_addr,
	output var  logic [7:0]        cmd_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code  = 8'h00;
		cmd_addr  = 24'h000000;
		cmd_data  = 8'h00;
	end
	// one-cycle command; fields scrambled once released
	task automatic send(input logic [7:0] code, input logic [ADDR_W-1:0] addr, input logic [7:0] data);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_code  <= code;
		cmd_addr  <= addr;
		cmd_data  <= data;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_code  <= ~code;
		cmd_addr  <= ~addr;
		cmd_data  <= ~data;
	endtask
	task automatic arm_write(input logic [7:0] code, input logic [ADDR_W-1:0] addr, input logic [7:0] data);
		send(ARM_WRITE_CMD, 24'h000000, 8'h00);
		send(code, addr, data);
	endtask
endmodule
`default_nettype wire

// *** test/test_shadow_register_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_shadow_register_bank
	import shadow_reg_pkg::*;
;
	localparam int ERASE_CYCLES   = 2;
	localparam int PROGRAM_CYCLES = 2;
	logic              sys_clk;
	logic              resetn;
	logic              reload_req;
	logic              wp_n;
	logic              cmd_valid;
	logic [7:0]        cmd_code;
	logic [ADDR_W-1:0] cmd_addr;
	logic [7:0]        cmd_data;
	logic              rsp_valid;
	logic [7:0]        rsp_data;
	logic [7:0]        status_one_working;
	int                num_errors = 0;
	int                samples_checked = 0;

	shadow_register_bank #(.ERASE_CYCLES(ERASE_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES)) u_dut (
		.sys_clk(sys_clk), .resetn(resetn), .reload_req(reload_req), .wp_n(wp_n),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .status_one_working(status_one_working));
	host_cmd_model u_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] code, input logic [ADDR_W-1:0] addr, input logic [7:0] exp);
		u_host.send(code, addr, 8'h00);
		// answer stands only in the cycle after the taking edge
		#1;
		chk({7'h00, rsp_valid}, 8'h01, "answer pulse");
		chk(rsp_data, exp, "read data");
	endtask
	task automatic wait_busy(input logic exp);
		logic seen;
		seen = 1'b0;
		for (int n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			#1;
			if (status_one_working[BUSY_POS] === 1'b1) seen = 1'b1;
			else if (seen || n > 4) break;
		end
		chk({7'h00, seen}, {7'h00, exp}, "busy seen");
		chk({7'h00, status_one_working[BUSY_POS]}, 8'h00, "busy end");
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults;
		chk(status_one_working, 8'h00, "working after reset");
		rd(STATUS_ONE_READ_CMD, 24'h000000, 8'h00);
		rd(GENERIC_REG_READ_CMD, 24'h000000, 8'h00);
		rd(GENERIC_REG_READ_CMD, 24'h800006, 8'h00);
		rd(GENERIC_REG_READ_CMD, 24'h000100, 8'h00);
		u_host.send(GENERIC_REG_WRITE_CMD, 24'h000000, 8'hFC);
		wait_busy(1'b0);
		rd(GENERIC_REG_READ_CMD, 24'h000000, 8'h00);
		$display("defaults done");
	endtask
	task automatic t_persistent;
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h000000, 8'hFF);
		wait_busy(1'b1);
		rd(GENERIC_REG_READ_CMD, 24'h000000, 8'hFC);
		rd(STATUS_ONE_READ_CMD, 24'h000000, 8'hFC);
		u_host.arm_write(LEGACY_REG_WRITE_CMD, 24'h000000, 8'hA4);
		wait_busy(1'b1);
		rd(GENERIC_REG_READ_CMD, 24'h000000, 8'hA4);
		chk(status_one_working, 8'hA4, "lock follows");
		rd(GENERIC_REG_READ_CMD, 24'h000100, 8'h00);
		@(posedge sys_clk);
		wp_n <= 1'b0;
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h800000, 8'h00);
		wait_busy(1'b0);
		// refused write leaves the arm latch set
		rd(STATUS_ONE_READ_CMD, 24'h000000, 8'hA6);
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h800006, 8'h3C);
		wait_busy(1'b0);
		rd(GENERIC_REG_READ_CMD, 24'h800006, 8'h3C);
		rd(STATUS_ONE_READ_CMD, 24'h000000, 8'hA4);
		@(posedge sys_clk);
		wp_n <= 1'b1;
		$display("persistent done");
	endtask
	task automatic t_working;
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h800000, 8'h10);
		wait_busy(1'b0);
		rd(STATUS_ONE_READ_CMD, 24'h000000, 8'h10);
		rd(GENERIC_REG_READ_CMD, 24'h000000, 8'hA4);
		@(posedge sys_clk);
		reload_req <= 1'b1;
		@(posedge sys_clk);
		reload_req <= 1'b0;
		rd(STATUS_ONE_READ_CMD, 24'h000000, 8'hA4);
		rd(GENERIC_REG_READ_CMD, 24'h800006, 8'h00);
		u_host.send(ARM_WRITE_CMD, 24'h000000, 8'h00);
		u_host.send(DISARM_WRITE_CMD, 24'h000000, 8'h00);
		u_host.send(GENERIC_REG_WRITE_CMD, 24'h800000, 8'h00);
		wait_busy(1'b0);
		rd(STATUS_ONE_READ_CMD, 24'h000000, 8'hA4);
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h000002, 8'h5C);
		wait_busy(1'b1);
		rd(GENERIC_REG_READ_CMD, 24'h800003, 8'h5C);
		rd(GENERIC_REG_READ_CMD, 24'h000002, 8'h5C);
		$display("working done");
	endtask
	task automatic t_otp;
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h000004, 8'h5A);
		wait_busy(1'b1);
		rd(GENERIC_REG_READ_CMD, 24'h800005, 8'h5A);
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h000004, 8'h81);
		wait_busy(1'b1);
		rd(GENERIC_REG_READ_CMD, 24'h000004, 8'hDB);
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h000012, 8'h3C);
		wait_busy(1'b1);
		rd(GENERIC_REG_READ_CMD, 24'h000012, 8'h3C);
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h00000E, 8'h0F);
		wait_busy(1'b1);
		u_host.arm_write(GENERIC_REG_WRITE_CMD, 24'h00000E, 8'hF0);
		wait_busy(1'b1);
		rd(GENERIC_REG_READ_CMD, 24'h00000E, 8'hFF);
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(GENERIC_REG_READ_CMD, 24'h000000, 8'h00);
		chk(status_one_working, 8'h00, "working after power-on");
		$display("otp done");
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		summarize();
	end
	initial begin
		resetn     = 1'b0;
		reload_req = 1'b0;
		wp_n       = 1'b1;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		t_defaults();
		t_persistent();
		t_working();
		t_otp();
		summarize();
	end
endmodule

bind shadow_register_bank shadow_register_bank_sva #(.ERASE_CYCLES(ERASE_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES)) u_sva (
	.sys_clk(sys_clk), .resetn(resetn), .reload_req(reload_req), .wp_n(wp_n),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
	.rsp_valid(rsp_valid), .rsp_data(rsp_data), .status_one_working(status_one_working));
`default_nettype wire
